/* rtl/spc_pkg.sv */
// Package for the sample pattern checker: register map, field positions,
// reset values and sequence constants.
// Assumes a byte-wide register port inside the device on one clock.
package spc_pkg;

    localparam logic [8:0] SPC_ADDR_CTRL      = 9'h14b;
    localparam logic [8:0] SPC_ADDR_ERR_REAL  = 9'h14c;
    localparam logic [8:0] SPC_ADDR_ERR_IMAG  = 9'h14d;

    localparam int SPC_BIT_ENABLE       = 0;
    localparam int SPC_BIT_CNT_CLEAR    = 1;
    localparam int SPC_BIT_POLY_SEL     = 2;
    localparam int SPC_BIT_REAL_INV     = 3;
    localparam int SPC_BIT_IMAG_INV     = 4;
    localparam int SPC_BIT_REAL_MATCH   = 6;
    localparam int SPC_BIT_IMAG_MATCH   = 7;

    localparam logic       SPC_RST_ENABLE     = 1'b0;
    localparam logic       SPC_RST_CNT_CLEAR  = 1'b0;
    localparam logic       SPC_RST_POLY_SEL   = 1'b0;
    localparam logic       SPC_RST_REAL_INV   = 1'b0;
    localparam logic       SPC_RST_IMAG_INV   = 1'b1;
    localparam logic [7:0] SPC_RST_ERR_COUNT  = 8'h00;
    localparam logic [7:0] SPC_ERR_COUNT_MAX  = 8'hff;

    // Sequence lengths and the sample width
    localparam int SPC_LEN_SHORT = 7;
    localparam int SPC_LEN_LONG  = 15;
    localparam int SPC_SAMPLE_W  = 16;

endpackage : spc_pkg

/* rtl/spc_lane_check.sv */
// One channel of the pattern checker: a self-synchronising sequence check.
// Assumes samples arrive on the same clock with a one-cycle valid strobe.
module spc_lane_check
    import spc_pkg::*;
(
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    srst,
    // Control
    input  wire logic                    enable,
    input  wire logic                    poly_sel,
    input  wire logic                    expect_inverted,
    input  wire logic                    count_clear,
    // Sample stream
    input  wire logic                    sample_valid,
    input  wire logic [SPC_SAMPLE_W-1:0] sample,
    // Status
    output logic                         match_ff,
    output logic [7:0]                   err_count_ff
);
    // Each sample contributes its lsb as one sequence bit; the history of
    // received bits predicts the next, so no seed alignment is needed.
    logic [SPC_LEN_LONG-1:0] hist_ff;
    logic [SPC_LEN_LONG-1:0] nxt_hist;
    logic                    rx_bit;
    logic                    exp_bit;
    logic                    mismatch;
    logic [3:0]              fill_ff;
    logic                    primed;

    assign rx_bit  = sample[0] ^ expect_inverted;
    assign exp_bit = poly_sel
                   ? hist_ff[SPC_LEN_LONG-1] ^ hist_ff[SPC_LEN_LONG-2]
                   : hist_ff[SPC_LEN_SHORT-1]
                     ^ hist_ff[SPC_LEN_SHORT-2];
    assign primed   = poly_sel ? (fill_ff >= 4'(SPC_LEN_LONG))
                               : (fill_ff >= 4'(SPC_LEN_SHORT));
    assign mismatch = enable && sample_valid && primed
                   && (rx_bit != exp_bit);
    assign nxt_hist = {hist_ff[SPC_LEN_LONG-2:0], rx_bit};

    always_ff @(posedge clock) begin
        if (srst || !enable) begin
            hist_ff <= '0;
            fill_ff <= 4'h0;
        end else if (sample_valid) begin
            hist_ff <= nxt_hist;
            if (fill_ff != 4'hf) begin
                fill_ff <= fill_ff + 4'h1;
            end
        end
    end

    // Flag drops on any mismatch and recovers on the next good sample
    always_ff @(posedge clock) begin
        if (srst || !enable) begin
            match_ff <= 1'b0;
        end else if (sample_valid && primed) begin
            match_ff <= !mismatch;
        end
    end

    // Saturating count; clear holds while the clear field stays set
    always_ff @(posedge clock) begin
        if (srst || count_clear) begin
            err_count_ff <= SPC_RST_ERR_COUNT;
        end else if (mismatch && err_count_ff != SPC_ERR_COUNT_MAX) begin
            err_count_ff <= err_count_ff + 8'h01;
        end
    end

    a_count_clears: assert property (
        @(posedge clock) disable iff (srst)
        count_clear |=> err_count_ff == SPC_RST_ERR_COUNT)
        else $error("error count not cleared");
    a_mismatch_counts: assert property (
        @(posedge clock) disable iff (srst)
        mismatch && !count_clear && err_count_ff != SPC_ERR_COUNT_MAX
        |=> err_count_ff == $past(err_count_ff) + 8'h01)
        else $error("mismatch not counted");
    a_flag_drops: assert property (
        @(posedge clock) disable iff (srst)
        mismatch |=> !match_ff)
        else $error("match flag stayed high on mismatch");
    a_idle_no_count: assert property (
        @(posedge clock) disable iff (srst)
        !enable && !count_clear |=> $stable(err_count_ff))
        else $error("count moved while disabled");

endmodule : spc_lane_check

/* rtl/spc_checker.sv */
// Sample pattern checker top: control and count registers on the
// device's byte register port, with one lane checker per channel.
// Assumes the register port and sample path share one clock.
//
// Functional notes
// - Bit 7 of control reads 1 while the imaginary channel matches.
// - Bit 6 of control reads 1 while the real channel matches.
// - Bits 3 and 4 select inverted expectation; resets 0 and 1.
// - Poly select 0 expects the x^7+x^6+1 sequence.
// - Poly select 1 expects x^15+x^14+1; field resets to 0.
// - Real mismatches count in an 8-bit read-only register at 0x14C.
// - Imaginary mismatches count in an 8-bit read-only register 0x14D.
module spc_checker
    import spc_pkg::*;
(
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    srst,
    // Register port
    input  wire logic [8:0]              reg_addr,
    input  wire logic                    reg_wr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_rd,
    output logic [7:0]                   reg_rdata_ff,
    // Incoming samples
    input  wire logic                    sample_valid,
    input  wire logic [SPC_SAMPLE_W-1:0] sample_real,
    input  wire logic [SPC_SAMPLE_W-1:0] sample_imag
);
    logic       enable_ff;
    logic       clear_ff;
    logic       poly_ff;
    logic       real_inv_ff;
    logic       imag_inv_ff;
    logic       real_match;
    logic       imag_match;
    logic [7:0] real_count;
    logic [7:0] imag_count;
    logic       sel_ctrl;
    logic       sel_real;
    logic       sel_imag;
    logic [7:0] ctrl_view;
    logic [7:0] nxt_rdata;
    logic [4:0] cfg_fields;

    // One compare form for every register keeps the decode uniform
    function automatic logic addr_hit(input logic [8:0] addr,
                                      input logic [8:0] offset);
        return addr == offset;
    endfunction : addr_hit

    assign sel_ctrl   = addr_hit(reg_addr, SPC_ADDR_CTRL);
    assign sel_real   = addr_hit(reg_addr, SPC_ADDR_ERR_REAL);
    assign sel_imag   = addr_hit(reg_addr, SPC_ADDR_ERR_IMAG);
    assign cfg_fields = {imag_inv_ff, real_inv_ff, poly_ff, clear_ff,
                         enable_ff};

    // Control fields take effect the cycle after the write
    always_ff @(posedge clock) begin
        if (srst) begin
            enable_ff   <= SPC_RST_ENABLE;
            clear_ff    <= SPC_RST_CNT_CLEAR;
            poly_ff     <= SPC_RST_POLY_SEL;
            real_inv_ff <= SPC_RST_REAL_INV;
            imag_inv_ff <= SPC_RST_IMAG_INV;
        end else if (reg_wr && sel_ctrl) begin
            enable_ff   <= reg_wdata[SPC_BIT_ENABLE];
            clear_ff    <= reg_wdata[SPC_BIT_CNT_CLEAR];
            poly_ff     <= reg_wdata[SPC_BIT_POLY_SEL];
            real_inv_ff <= reg_wdata[SPC_BIT_REAL_INV];
            imag_inv_ff <= reg_wdata[SPC_BIT_IMAG_INV];
        end
    end

    // Status bits and bit 5 are read-only; writes to them are dropped
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[SPC_BIT_IMAG_MATCH] = imag_match;
        ctrl_view[SPC_BIT_REAL_MATCH] = real_match;
        ctrl_view[SPC_BIT_IMAG_INV]   = imag_inv_ff;
        ctrl_view[SPC_BIT_REAL_INV]   = real_inv_ff;
        ctrl_view[SPC_BIT_POLY_SEL]   = poly_ff;
        ctrl_view[SPC_BIT_CNT_CLEAR]  = clear_ff;
        ctrl_view[SPC_BIT_ENABLE]     = enable_ff;
    end

    assign nxt_rdata = sel_ctrl ? ctrl_view
                     : sel_real ? real_count
                     : sel_imag ? imag_count
                     : 8'h00;

    // Read data holds between reads, so a slow master can still take it
    always_ff @(posedge clock) begin
        if (srst) begin
            reg_rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_ff <= nxt_rdata;
        end
    end

    spc_lane_check u_real (
        .clock           (clock),
        .srst            (srst),
        .enable          (enable_ff),
        .poly_sel        (poly_ff),
        .expect_inverted (real_inv_ff),
        .count_clear     (clear_ff),
        .sample_valid    (sample_valid),
        .sample          (sample_real),
        .match_ff        (real_match),
        .err_count_ff    (real_count)
    );

    spc_lane_check u_imag (
        .clock           (clock),
        .srst            (srst),
        .enable          (enable_ff),
        .poly_sel        (poly_ff),
        .expect_inverted (imag_inv_ff),
        .count_clear     (clear_ff),
        .sample_valid    (sample_valid),
        .sample          (sample_imag),
        .match_ff        (imag_match),
        .err_count_ff    (imag_count)
    );

    // Register-side checks; sequence checks sit in each lane
    a_read_counts: assert property (
        @(posedge clock) disable iff (srst)
        reg_rd && sel_real |=> reg_rdata_ff == $past(real_count))
        else $error("real count read wrong");

    a_read_imag: assert property (
        @(posedge clock) disable iff (srst)
        reg_rd && sel_imag |=> reg_rdata_ff == $past(imag_count))
        else $error("imag count read wrong");

    a_read_flags: assert property (
        @(posedge clock) disable iff (srst)
        reg_rd && sel_ctrl
        |=> reg_rdata_ff[SPC_BIT_IMAG_MATCH] == $past(imag_match))
        else $error("imag match flag read wrong");

    a_read_real_flag: assert property (
        @(posedge clock) disable iff (srst)
        reg_rd && sel_ctrl
        |=> reg_rdata_ff[SPC_BIT_REAL_MATCH] == $past(real_match))
        else $error("real match flag read wrong");

    a_read_config: assert property (
        @(posedge clock) disable iff (srst)
        reg_rd && sel_ctrl |=> reg_rdata_ff[SPC_BIT_IMAG_INV:SPC_BIT_ENABLE]
            == $past(cfg_fields))
        else $error("control fields read wrong");

    a_read_unmapped: assert property (
        @(posedge clock) disable iff (srst)
        reg_rd && !sel_ctrl && !sel_real && !sel_imag
        |=> reg_rdata_ff == 8'h00)
        else $error("unmapped read not zero");

    a_rdata_hold: assert property (
        @(posedge clock) disable iff (srst)
        !reg_rd |=> $stable(reg_rdata_ff))
        else $error("read data moved without a read");

    a_ctrl_write: assert property (
        @(posedge clock) disable iff (srst)
        reg_wr && sel_ctrl |=> {imag_inv_ff, real_inv_ff}
            == $past(reg_wdata[SPC_BIT_IMAG_INV:SPC_BIT_REAL_INV]))
        else $error("inversion fields not written");

    a_poly_write: assert property (
        @(posedge clock) disable iff (srst)
        reg_wr && sel_ctrl |=> poly_ff == $past(reg_wdata[SPC_BIT_POLY_SEL]))
        else $error("polynomial select not written");

    a_enable_write: assert property (
        @(posedge clock) disable iff (srst)
        reg_wr && sel_ctrl |=> {clear_ff, enable_ff}
            == $past(reg_wdata[SPC_BIT_CNT_CLEAR:SPC_BIT_ENABLE]))
        else $error("enable or clear not written");

    a_ctrl_hold: assert property (
        @(posedge clock) disable iff (srst)
        !(reg_wr && sel_ctrl) |=> $stable(cfg_fields))
        else $error("control changed without a write");

    a_reset_inv: assert property (
        @(posedge clock) disable iff (srst)
        $past(srst) |-> !real_inv_ff && imag_inv_ff && !poly_ff)
        else $error("control reset values wrong");

    a_reset_ctrl: assert property (
        @(posedge clock) disable iff (srst)
        $past(srst) |-> enable_ff == SPC_RST_ENABLE
            && clear_ff == SPC_RST_CNT_CLEAR)
        else $error("enable or clear reset value wrong");

    a_reset_counts: assert property (
        @(posedge clock) disable iff (srst)
        $past(srst) |-> real_count == SPC_RST_ERR_COUNT)
        else $error("real count not reset");

    a_reset_imag_count: assert property (
        @(posedge clock) disable iff (srst)
        $past(srst) |-> imag_count == SPC_RST_ERR_COUNT)
        else $error("imag count not reset");

    a_reset_flags: assert property (
        @(posedge clock) disable iff (srst)
        $past(srst) |-> !imag_match && !real_match)
        else $error("match flags not reset");

    a_clear_both: assert property (
        @(posedge clock) disable iff (srst)
        clear_ff |=> real_count == 8'h00 && imag_count == 8'h00)
        else $error("clear left a count standing");

    a_disabled_flags: assert property (
        @(posedge clock) disable iff (srst)
        !enable_ff |=> !real_match && !imag_match)
        else $error("match flag high while disabled");

    a_imag_flag_enabled: assert property (
        @(posedge clock) disable iff (srst)
        imag_match |-> $past(enable_ff))
        else $error("imag flag set without enable");

    a_real_flag_enabled: assert property (
        @(posedge clock) disable iff (srst)
        real_match |-> $past(enable_ff))
        else $error("real flag set without enable");

endmodule : spc_checker

/* verif/spc_src_model.sv */
// Source model: the link logic that sends the test sequence on bit 0.
// Assumes the bench drives its controls just after the clock edge.
module spc_src_model
    import spc_pkg::*;
(
    // Clock and reset
    input  wire logic                    clock,
    input  wire logic                    srst,
    // Stream control
    input  wire logic                    run,
    input  wire logic                    poly_sel,
    input  wire logic                    inv_real,
    input  wire logic                    inv_imag,
    input  wire logic                    flip_real,
    // Sample stream
    output logic                         sample_valid,
    output logic [SPC_SAMPLE_W-1:0]      sample_real,
    output logic [SPC_SAMPLE_W-1:0]      sample_imag
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [14:0] lfsr_ff;
    logic        nxt_bit;

    // Newest sent bit sits in lfsr_ff[0]
    assign nxt_bit = poly_sel ? lfsr_ff[14] ^ lfsr_ff[13]
                              : lfsr_ff[6] ^ lfsr_ff[5];

    // Idle samples toggle so a checker can not lean on stale values
    always_ff @(posedge clock) begin
        if (srst) begin
            lfsr_ff <= 15'h0001;
            sample_valid <= 1'b0;
            sample_real <= 16'h0000;
            sample_imag <= 16'h0000;
        end else if (run) begin
            lfsr_ff <= {lfsr_ff[13:0], nxt_bit};
            sample_valid <= 1'b1;
            sample_real <= {lfsr_ff, nxt_bit ^ inv_real ^ flip_real};
            sample_imag <= {~lfsr_ff, nxt_bit ^ inv_imag};
        end else begin
            sample_valid <= 1'b0;
            sample_real <= ~sample_real;
            sample_imag <= ~sample_imag;
        end
    end
endmodule : spc_src_model

/* verif/testbench.sv */
// Testbench: register reads and writes around bursts of test samples.
// Assumes a one-cycle read latency and a self-synchronising checker.
module testbench
    import spc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, srst, reg_wr, reg_rd, run, poly, inv_r, inv_i, flip;
    logic [8:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata_ff, cfg;
    logic sample_valid;
    logic [SPC_SAMPLE_W-1:0] sample_real, sample_imag;
    int fail_count, checked, cycles;

    spc_checker spc_checker_i (.clock(clock), .srst(srst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .sample_valid(sample_valid), .sample_real(sample_real),
        .sample_imag(sample_imag));
    spc_src_model spc_src_model_i (.clock(clock), .srst(srst), .run(run),
        .poly_sel(poly), .inv_real(inv_r), .inv_imag(inv_i),
        .flip_real(flip), .sample_valid(sample_valid),
        .sample_real(sample_real), .sample_imag(sample_imag));

    always #50 clock = ~clock;

    task automatic cyc;
        @(posedge clock);
        #10;
    endtask : cyc

    task automatic chk(input string n, input logic [7:0] s, e);
        checked++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        cyc();
        reg_wr = 1'b0;
        cyc();
    endtask : wr

    task automatic rd(input logic [8:0] a, input logic [7:0] e, string n);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc();
        reg_rd = 1'b0;
        chk(n, reg_rdata_ff, e);
        cyc();
    endtask : rd

    // Flip only the first sample of the burst when asked
    task automatic go(input int n, input logic f);
        run = 1'b1;
        flip = f;
        cyc();
        flip = 1'b0;
        repeat (n - 1) cyc();
        run = 1'b0;
        cyc();
        cyc();
    endtask : go

    task automatic final_report;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    // Whole run needs about 620 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            final_report();
        end
    end

    initial begin
        clock = 1'b0;
        srst = 1'b1;
        {reg_wr, reg_rd, run, poly, inv_r, inv_i, flip} = 7'h00;
        reg_addr = 9'h000;
        reg_wdata = 8'h00;
        repeat (5) cyc();
        srst = 1'b0;
        rd(SPC_ADDR_CTRL, 8'h10, "ctrl reset");
        wr(SPC_ADDR_ERR_REAL, 8'h55);
        rd(SPC_ADDR_ERR_REAL, 8'h00, "real ro");
        rd(9'h14e, 8'h00, "unmapped");
        go(30, 1'b0);
        rd(SPC_ADDR_CTRL, 8'h10, "ctrl idle");
        rd(SPC_ADDR_ERR_IMAG, 8'h00, "imag idle");
        $display("test reset and idle done");
        for (int p = 0; p < 2; p++) begin
            for (int iv = 0; iv < 2; iv++) begin
                poly = p[0];
                inv_r = iv[0];
                inv_i = iv[0];
                cfg = {3'h0, iv[0], iv[0], p[0], 2'h1};
                wr(SPC_ADDR_CTRL, 8'h00);
                wr(SPC_ADDR_CTRL, cfg);
                go(40, 1'b0);
                rd(SPC_ADDR_CTRL, cfg | 8'hc0, "ctrl good");
                rd(SPC_ADDR_ERR_REAL, 8'h00, "real good");
                rd(SPC_ADDR_ERR_IMAG, 8'h00, "imag good");
            end
        end
        $display("test sequences done");
        poly = 1'b1;
        inv_r = 1'b0;
        inv_i = 1'b1;
        wr(SPC_ADDR_CTRL, 8'h00);
        wr(SPC_ADDR_CTRL, 8'h05);
        go(20, 1'b0);
        go(300, 1'b1);
        // One flipped bit is seen again at both taps
        rd(SPC_ADDR_ERR_REAL, 8'h03, "real errs");
        rd(SPC_ADDR_ERR_IMAG, 8'hff, "imag sat");
        rd(SPC_ADDR_CTRL, 8'h45, "ctrl flags");
        $display("test errors done");
        wr(SPC_ADDR_CTRL, 8'h07);
        rd(SPC_ADDR_ERR_REAL, 8'h00, "real clr");
        rd(SPC_ADDR_ERR_IMAG, 8'h00, "imag clr");
        wr(SPC_ADDR_CTRL, 8'h05);
        go(10, 1'b0);
        rd(SPC_ADDR_ERR_IMAG, 8'h0a, "imag resume");
        $display("test clear done");
        // Reset in mid-run must drop a nonzero count and restore control
        srst = 1'b1;
        cyc();
        srst = 1'b0;
        rd(SPC_ADDR_ERR_IMAG, 8'h00, "imag mid reset");
        rd(SPC_ADDR_CTRL, 8'h10, "ctrl mid reset");
        $display("test mid reset done");
        final_report();
    end
endmodule : testbench
